// ### core/sipo_pkg.sv
// Constants shared by the serial-in parallel-out shift register
// How it works
// - Eight stages are held and each one drives its own parallel output bit at all times.
// - Each serial input acts as an active-high gate on the other, so a low on either enters a zero.
// - On a shift the first stage loads the AND of both serial inputs as they stood before the edge.
// - On each rising shift clock every stage after the first takes its neighbour's old value and the last bit drops out.
// - A low clear empties all eight stages at once, without a clock, and holds every output low.
package sipo_pkg;

  localparam int unsigned STAGE_COUNT = 8;

  typedef logic [STAGE_COUNT-1:0] sipo_stage_t;

  localparam sipo_stage_t STAGE_RST      = 8'h00;
  localparam logic        SHCLK_PREV_RST = 1'h1;
  localparam logic        ENTRY_RST      = 1'h0;

  // Shifts counted since the last clear, saturating once every stage has been filled
  typedef logic [3:0] sipo_fill_t;

  localparam sipo_fill_t FILL_RST  = 4'h0;
  localparam sipo_fill_t FILL_FULL = 4'h8;

endpackage

// ### core/sipo_entry_if.sv
// Carrier for the shift strobe and entry bit between entry logic and stages
`timescale 1ns/10ps
interface sipo_entry_if;
  logic shift_en;
  logic entry_bit;

  modport src (output shift_en, output entry_bit);
  modport dst (input  shift_en, input  entry_bit);
endinterface

// ### core/sipo_entry.sv
// Shift clock edge detection and gated serial entry
`timescale 1ns/10ps
module sipo_entry
  import sipo_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   clr_n_i,
  input  wire logic   serial_in_a_i,
  input  wire logic   serial_in_b_i,
  input  wire logic   shift_clock_i,
  sipo_entry_if.src   ent
);

  logic shclk_prev_q;
  logic entry_q;

  // Reset high so a shift clock already high at clear release is no edge
  always_ff @(posedge clk_i or negedge clr_n_i)
  begin
    if (!clr_n_i)
      shclk_prev_q <= SHCLK_PREV_RST;
    else
      shclk_prev_q <= shift_clock_i;
  end

  // Entry is taken one cycle before the edge is seen, like a setup window
  always_ff @(posedge clk_i or negedge clr_n_i)
  begin
    if (!clr_n_i)
      entry_q <= ENTRY_RST;
    else
      entry_q <= serial_in_a_i & serial_in_b_i;
  end

  assign ent.shift_en  = shift_clock_i & ~shclk_prev_q;
  assign ent.entry_bit = entry_q;

endmodule // sipo_entry

// ### core/sipo_shift_reg.sv
// Eight-stage serial-in parallel-out shift register, top level
`timescale 1ns/10ps
module sipo_shift_reg
  import sipo_pkg::*;
(
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   RST_N_I,
  input  wire logic                   SERIAL_IN_A_I,
  input  wire logic                   SERIAL_IN_B_I,
  input  wire logic                   SHIFT_CLOCK_I,
  input  wire logic                   CLEAR_N_I,
  output logic [STAGE_COUNT-1:0]      STAGE_OUTPUTS_O
);

  sipo_entry_if ent ();

  logic        clr_n;
  sipo_stage_t stage_q;
  sipo_stage_t stage_d;

  // Pin clear and system reset share the asynchronous path
  assign clr_n = RST_N_I & CLEAR_N_I;

  sipo_entry u_entry (
    .clk_i         (CORE_CLK_I),
    .clr_n_i       (clr_n),
    .serial_in_a_i (SERIAL_IN_A_I),
    .serial_in_b_i (SERIAL_IN_B_I),
    .shift_clock_i (SHIFT_CLOCK_I),
    .ent           (ent.src)
  );

  // One shift step: new bit into the first stage, the last stage falls off the end
  function automatic sipo_stage_t sipo_shift_in(sipo_stage_t pattern, logic new_bit);
    return {pattern[STAGE_COUNT-2:0], new_bit};
  endfunction

  assign stage_d = sipo_shift_in(stage_q, ent.entry_bit);

  always_ff @(posedge CORE_CLK_I or negedge clr_n)
  begin
    if (!clr_n)
      stage_q <= STAGE_RST;
    else if (ent.shift_en)
      stage_q <= stage_d;
  end

  // Last stage is the cascade point for a longer chain
  assign STAGE_OUTPUTS_O = stage_q;

  AST_SHIFT_MOVES: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    ent.shift_en |=> stage_q[STAGE_COUNT-1:1] == $past(stage_q[STAGE_COUNT-2:0]))
    else $error("Stages did not move one place on a shift");

  AST_FIRST_STAGE_AND: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (SERIAL_IN_A_I && SERIAL_IN_B_I && !ent.shift_en) ##1 ent.shift_en
      |=> STAGE_OUTPUTS_O[0])
    else $error("First stage missed a high entry");

  AST_GATE_BLOCKS: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (!(SERIAL_IN_A_I && SERIAL_IN_B_I) && !ent.shift_en) ##1 ent.shift_en
      |=> !STAGE_OUTPUTS_O[0])
    else $error("Gated entry let a one through");

  AST_HOLD_NO_EDGE: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    !ent.shift_en |=> $stable(STAGE_OUTPUTS_O))
    else $error("Outputs changed without a shift edge");

  AST_EDGE_ONLY_RISE: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (SHIFT_CLOCK_I && ent.shift_en) |=> (SHIFT_CLOCK_I |-> !ent.shift_en))
    else $error("High shift clock shifted twice");

  AST_CLEAR_LOW: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    !CLEAR_N_I |-> STAGE_OUTPUTS_O == STAGE_RST)
    else $error("Outputs not low during clear");

  // Checker-only count of shifts since clear; stages not yet reached must still be zero
  sipo_fill_t fill_q;

  always_ff @(posedge CORE_CLK_I or negedge clr_n)
  begin
    if (!clr_n)
      fill_q <= FILL_RST;
    else if (ent.shift_en && (fill_q != FILL_FULL))
      fill_q <= fill_q + 4'h1;
  end

  AST_FILL_FROM_ZERO: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (fill_q != FILL_FULL) |-> (STAGE_OUTPUTS_O >> fill_q) == STAGE_RST)
    else $error("A stage not yet reached after clear is not zero");

  AST_FILL_STEPS: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (ent.shift_en && (fill_q != FILL_FULL)) |=> fill_q == $past(fill_q) + 4'h1)
    else $error("Fill count missed a shift");

  AST_FILL_HOLDS: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    !ent.shift_en |=> $stable(fill_q))
    else $error("Fill count moved without a shift");

  AST_FULL_SATURATES: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (fill_q == FILL_FULL) |=> fill_q == FILL_FULL)
    else $error("Fill count left the full state");

  AST_CLEAR_FILL: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    $rose(clr_n) |-> fill_q == FILL_RST)
    else $error("Fill count not empty after clear");

  // Entry path checks against the pins and the entry bit
  AST_ENTRY_HIGH: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (SERIAL_IN_A_I && SERIAL_IN_B_I) |=> ent.entry_bit)
    else $error("Entry bit low although both serial inputs were high");

  AST_ENTRY_LOW_GATE: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    !(SERIAL_IN_A_I && SERIAL_IN_B_I) |=> !ent.entry_bit)
    else $error("Entry bit high although a serial input was low");

  AST_ENTRY_A_GATES: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    !SERIAL_IN_A_I |=> !ent.entry_bit)
    else $error("Low input A did not block entry");

  AST_ENTRY_B_GATES: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    !SERIAL_IN_B_I |=> !ent.entry_bit)
    else $error("Low input B did not block entry");

  AST_BIT0_FOLLOWS_ENTRY: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    ent.shift_en |=> STAGE_OUTPUTS_O[0] == $past(ent.entry_bit))
    else $error("First stage did not take the entry bit");

  AST_NEXT_PATTERN: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    ent.shift_en
      |=> STAGE_OUTPUTS_O == sipo_shift_in($past(STAGE_OUTPUTS_O), $past(ent.entry_bit)))
    else $error("Pattern after a shift is wrong");

  // Edge detection checks against the shift clock pin
  AST_EDGE_NEEDS_LOW: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    ent.shift_en |-> (SHIFT_CLOCK_I && !$past(SHIFT_CLOCK_I)))
    else $error("Shift without a low to high shift clock");

  AST_RISE_SHIFTS: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (!SHIFT_CLOCK_I ##1 SHIFT_CLOCK_I) |-> ent.shift_en)
    else $error("Rising shift clock gave no shift");

  AST_LOW_CLOCK_NO_SHIFT: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    !SHIFT_CLOCK_I |-> !ent.shift_en)
    else $error("Shift while the shift clock was low");

  AST_SHIFT_SPACING: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    ent.shift_en |=> !ent.shift_en)
    else $error("Two shifts on neighbouring cycles");

  AST_HIGH_CLOCK_HOLDS: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    (SHIFT_CLOCK_I && $past(SHIFT_CLOCK_I)) |=> $stable(STAGE_OUTPUTS_O))
    else $error("Outputs moved while the shift clock stayed high");

  // Clear and reset checks
  AST_RESET_LOW: assert property (
    @(posedge CORE_CLK_I)
    !RST_N_I |-> STAGE_OUTPUTS_O == STAGE_RST)
    else $error("Outputs not low during reset");

  AST_NO_SHIFT_IN_CLEAR: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    !CLEAR_N_I |=> STAGE_OUTPUTS_O == STAGE_RST)
    else $error("Outputs left zero right after clear");

  AST_NO_SHIFT_AT_RELEASE: assert property (
    @(posedge CORE_CLK_I) disable iff (!clr_n)
    $rose(clr_n) |-> (!ent.shift_en && !ent.entry_bit))
    else $error("Shift or entry left over at clear release");

  // Each stage after the first takes its neighbour's old bit
  for (genvar i = 1; i < STAGE_COUNT; i++)
  begin : g_stage_step
    AST_STAGE_STEP: assert property (
      @(posedge CORE_CLK_I) disable iff (!clr_n)
      ent.shift_en |=> STAGE_OUTPUTS_O[i] == $past(STAGE_OUTPUTS_O[i-1]))
      else $error("A stage missed its neighbour's bit");
  end

endmodule // sipo_shift_reg

// ### testbench/sipo_far_end.sv
// Far-end logic model: shift clock source
`timescale 1ns/10ps
module sipo_far_end (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic slow_i,
  output logic      sck_o
);
  logic [1:0] hold_q;
  // Fast: one cycle high, one low. Slow: three each, so a held-high clock gives one shift
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_o  <= 1'b0;
      hold_q <= 2'h0;
    end
    else if (!en_i)
    begin
      sck_o  <= 1'b0;
      hold_q <= 2'h0;
    end
    else if (!slow_i || (hold_q == 2'h2))
    begin
      sck_o  <= ~sck_o;
      hold_q <= 2'h0;
    end
    else
      hold_q <= hold_q + 2'h1;
  end
endmodule // sipo_far_end

// ### testbench/tb_sipo_shift_reg.sv
// Self-checking bench for the shift register
`timescale 1ns/10ps
module tb_sipo_shift_reg;
  import sipo_pkg::*;
  logic        clk, rst_n, a, b, clr_n, en, sck, ent;
  logic        slow, tie_ab, sck_last, sck_older;
  sipo_stage_t q, exp_q, q_c, exp_c;
  int          num_errors = 0;
  int          check_count = 0;
  sipo_shift_reg uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .SERIAL_IN_A_I(a),
    .SERIAL_IN_B_I(b), .SHIFT_CLOCK_I(sck), .CLEAR_N_I(clr_n), .STAGE_OUTPUTS_O(q));
  // Second register fed from the last stage, unused input held high
  sipo_shift_reg uut_cascade (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .SERIAL_IN_A_I(q[STAGE_COUNT-1]), .SERIAL_IN_B_I(1'b1),
    .SHIFT_CLOCK_I(sck), .CLEAR_N_I(clr_n), .STAGE_OUTPUTS_O(q_c));
  sipo_far_end far (.clk_i(clk), .rst_n_i(rst_n), .en_i(en), .slow_i(slow), .sck_o(sck));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(string what, sipo_stage_t e, sipo_stage_t seen);
    check_count++;
    if (seen !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic sipo_stage_t next_pattern(sipo_stage_t p, logic new_bit);
    return {p[STAGE_COUNT-2:0], new_bit};
  endfunction
  // A shift is a high shift clock after a low one; entry changes just after a shift
  task automatic run_shifts(int n);
    int k;
    k = 0;
    while (k < n)
    begin
      @(posedge clk);
      #1;
      if (sck_last && !sck_older)
      begin
        exp_c = next_pattern(exp_c, exp_q[STAGE_COUNT-1]);
        exp_q = next_pattern(exp_q, ent);
        check("stages", exp_q, q);
        check("cascade", exp_c, q_c);
        a = 1'($urandom) | (k < 8);
        b = tie_ab ? a : 1'b1;
        ent = a & b;
        k++;
      end
      sck_older = sck_last;
      sck_last = sck;
    end
  endtask
  initial
  begin
    {a, b, ent, en, slow, tie_ab} = 6'h00;
    rst_n = 1'b1;
    clr_n = 1'b1;
    exp_q = STAGE_RST;
    exp_c = STAGE_RST;
    sck_last = 1'b0;
    sck_older = SHCLK_PREV_RST;
    void'($urandom(32'h0000_77ed));
    // Reset falls after time zero so its edge is not lost to start-up order
    #1;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    en = 1'b1;
    run_shifts(40);
    $display("test shifting done");
    slow = 1'b1;
    tie_ab = 1'b1;
    run_shifts(20);
    $display("test held clock done");
    @(posedge clk);
    #1;
    clr_n = 1'b0;
    en = 1'b0;
    #1;
    exp_q = STAGE_RST;
    exp_c = STAGE_RST;
    check("clear", exp_q, q);
    check("clear cascade", exp_c, q_c);
    repeat (2) @(posedge clk);
    #1;
    clr_n = 1'b1;
    en = 1'b1;
    slow = 1'b0;
    sck_last = sck;
    sck_older = SHCLK_PREV_RST;
    run_shifts(20);
    $display("test clear done");
    report_and_stop();
  end
  initial
  begin
    // About 260 cycles are needed; 1000 cycles leaves ample margin
    #5000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb_sipo_shift_reg
